// file: pkg/p4cs_pkg.sv
// Purpose: Shared constants, types and field helpers of the port 4 chip-select block
// Assumes: Registers sit behind a 32-bit classic Wishbone slave, one word per register
// Notes:   Register offsets are word indices; the byte address is four times the index

package p4cs_pkg;

  // Geometry
  localparam int unsigned P4CS_PINS    = 4;
  localparam int unsigned P4CS_ADDR_W  = 16;
  localparam int unsigned P4CS_FIELD_W = 4;

  // Register word indices
  localparam logic [7:0] P4CS_IDX_CTRL_LO = 8'h92;
  localparam logic [7:0] P4CS_IDX_CTRL_HI = 8'h93;
  localparam logic [P4CS_PINS-1:0][7:0] P4CS_IDX_BASE_LO = {8'h9c, 8'h9a, 8'h96, 8'h94};
  localparam logic [P4CS_PINS-1:0][7:0] P4CS_IDX_BASE_HI = {8'h9d, 8'h9b, 8'h97, 8'h95};
  localparam logic [7:0] P4CS_IDX_POLARITY = 8'ha2;
  localparam logic [7:0] P4CS_IDX_PORT_DATA = 8'hd8;

  // Field positions inside a pin's four-bit control field
  localparam int unsigned P4CS_MODE_LSB = 2;
  localparam int unsigned P4CS_CMP_LSB  = 0;
  // Polarity bits of pins 3..0 in the polarity register
  localparam int unsigned P4CS_POL_LSB  = 4;

  // Reset values
  localparam logic [7:0]           P4CS_CTRL_RST  = 8'h00;
  localparam logic [15:0]          P4CS_BASE_RST  = 16'h0000;
  localparam logic [P4CS_PINS-1:0] P4CS_POL_RST   = 4'h0;
  localparam logic [P4CS_PINS-1:0] P4CS_LATCH_RST = 4'hf;

  // Address compare masks
  localparam logic [15:0] P4CS_MASK_FULL  = 16'hffff;
  localparam logic [15:0] P4CS_MASK_A15_1 = 16'hfffe;
  localparam logic [15:0] P4CS_MASK_A15_2 = 16'hfffc;
  localparam logic [15:0] P4CS_MASK_A15_8 = 16'hff00;

  typedef enum logic [1:0] {
    P4CS_MODE_GPIO,
    P4CS_MODE_READ,
    P4CS_MODE_WRITE,
    P4CS_MODE_RDWR
  } p4cs_mode_t;

  typedef enum logic [1:0] {
    P4CS_CMP_FULL,
    P4CS_CMP_A15_1,
    P4CS_CMP_A15_2,
    P4CS_CMP_A15_8
  } p4cs_cmp_t;

  // External data bus access as seen by the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
  } p4cs_ext_bus_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } p4cs_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } p4cs_wb_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    logic [1:0][7:0]            ctrl;
    logic [P4CS_PINS-1:0][15:0] base;
    logic [P4CS_PINS-1:0]       pol;
    logic [P4CS_PINS-1:0]       latch;
    logic [P4CS_PINS-1:0]       pin_o;
    logic [P4CS_PINS-1:0]       pin_oe_n;
    logic                       ack;
    logic [31:0]                dat;
  } p4cs_state_t;

  // Four-bit field of one pin out of the two control registers
  function automatic logic [3:0] p4cs_field(input logic [1:0][7:0] ctrl, input int unsigned p);
    logic [7:0] r;
    r = ctrl[p / 2];
    return (p % 2 == 1) ? r[7:4] : r[3:0];
  endfunction

  function automatic p4cs_mode_t p4cs_pin_mode(input logic [1:0][7:0] ctrl, input int unsigned p);
    logic [3:0] f;
    f = p4cs_field(ctrl, p);
    return p4cs_mode_t'(f[P4CS_MODE_LSB +: 2]);
  endfunction

  function automatic p4cs_cmp_t p4cs_pin_cmp(input logic [1:0][7:0] ctrl, input int unsigned p);
    logic [3:0] f;
    f = p4cs_field(ctrl, p);
    return p4cs_cmp_t'(f[P4CS_CMP_LSB +: 2]);
  endfunction

endpackage

// file: hw/p4cs_sync.sv
// Purpose: Two-flop synchroniser for the port 4 pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes:   Only the second stage is visible outside

`timescale 1ns/1ps
`default_nettype none

module p4cs_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // Two stages; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule

`default_nettype wire

// file: hw/p4cs_match.sv
// Purpose: Address compare and strobe qualification for one port 4 pin
// Assumes: Bus strobes are same-clock signals from the core
// Notes:   Purely combinational; the top registers the result

`timescale 1ns/1ps
`default_nettype none

module p4cs_match
  import p4cs_pkg::*;
(
  input  wire p4cs_ext_bus_t bus,
  input  wire logic [15:0]   base,
  input  wire p4cs_mode_t    mode,
  input  wire p4cs_cmp_t     cmp,
  output logic               hit
);

  logic [15:0] mask;
  logic        addr_eq;

  // Mask of the address bits taking part in the compare
  always_comb begin
    case (cmp)
      P4CS_CMP_FULL:  mask = P4CS_MASK_FULL;
      P4CS_CMP_A15_1: mask = P4CS_MASK_A15_1;
      P4CS_CMP_A15_2: mask = P4CS_MASK_A15_2;
      default:        mask = P4CS_MASK_A15_8;
    endcase
  end

  assign addr_eq = (((bus.addr ^ base) & mask) == 16'h0000);

  // Qualify by access direction; fetches never raise rd or wr
  always_comb begin
    case (mode)
      P4CS_MODE_READ:  hit = addr_eq & bus.rd;
      P4CS_MODE_WRITE: hit = addr_eq & bus.wr;
      P4CS_MODE_RDWR:  hit = addr_eq & (bus.rd | bus.wr);
      default:         hit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// file: hw/p4cs_top.sv
// Purpose: Port 4 chip-select decoder with Wishbone register access
// Assumes: ext_bus comes from the core on the same clock; port4 pins are asynchronous
// Notes:   Pin outputs are registered, so a strobe trails the bus strobe by one cycle
//
// What this block does
// - Mode 00: pin is plain quasi-bidirectional I/O
// - Mode 01: strobe on external reads in range
// - Mode 10: strobe on external writes in range
// - Mode 11: strobe on reads and writes
// - Compare 00: all sixteen address bits
// - Compare 01: bits 15..1, ignore bit 0
// - Compare 10: bits 15..2, ignore bits 1..0
// - Compare 11: bits 15..8, 256-byte block
// - High control register: pin 3 high, pin 2 low
// - Pin 0 base split into low and high bytes
// - Pin 1 base split into low and high bytes
// - Low control register: pin 1 high, pin 0 low
// - Polarity bit set: active high, clear: low
// - Pins 2, 3 base bytes laid out alike

`timescale 1ns/1ps
`default_nettype none

module p4cs_top
  import p4cs_pkg::*;
#(
  parameter int unsigned PINS = P4CS_PINS
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire p4cs_wb_req_t  wb_req,
  output p4cs_wb_rsp_t       wb_rsp,
  input  wire p4cs_ext_bus_t ext_bus,
  input  wire logic [PINS-1:0] port4_pin_i,
  output logic      [PINS-1:0] port4_pin_o,
  output logic      [PINS-1:0] port4_pin_oe_n
);

  p4cs_state_t     st_reg;
  p4cs_state_t     st_next;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] hit;
  logic [7:0]      idx;
  logic            in_range;
  logic            req;
  logic            wr_go;
  logic [7:0]      wbyte;
  logic [31:0]     rd_data;

  // Pin inputs pass two flops before use
  p4cs_sync #(
    .W (PINS)
  ) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .async_i (port4_pin_i),
    .sync_o  (pin_sync)
  );

  // One address matcher per pin
  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++) begin : g_pin
      p4cs_match u_match (
        .bus  (ext_bus),
        .base (st_reg.base[gp]),
        .mode (p4cs_pin_mode(st_reg.ctrl, gp)),
        .cmp  (p4cs_pin_cmp(st_reg.ctrl, gp)),
        .hit  (hit[gp])
      );
    end
  endgenerate

  // Bus request decode
  assign idx      = wb_req.adr[9:2];
  assign in_range = (wb_req.adr[31:10] == 22'h000000);
  assign req      = wb_req.cyc & wb_req.stb;
  assign wr_go    = req & wb_req.we & st_reg.ack & wb_req.sel[0];
  assign wbyte    = wb_req.dat[7:0];

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rd_data = 32'h00000000;
    if (!in_range) begin
      rd_data = 32'h00000000;
    end else if (idx == P4CS_IDX_CTRL_LO) begin
      rd_data = {24'h000000, st_reg.ctrl[0]};
    end else if (idx == P4CS_IDX_CTRL_HI) begin
      rd_data = {24'h000000, st_reg.ctrl[1]};
    end else if (idx == P4CS_IDX_POLARITY) begin
      rd_data = {24'h000000, st_reg.pol, 4'h0};
    end else if (idx == P4CS_IDX_PORT_DATA) begin
      rd_data = {28'h0000000, pin_sync};
    end else begin
      for (int p = 0; p < PINS; p++) begin
        if (idx == P4CS_IDX_BASE_LO[p]) begin
          rd_data = {24'h000000, st_reg.base[p][7:0]};
        end else if (idx == P4CS_IDX_BASE_HI[p]) begin
          rd_data = {24'h000000, st_reg.base[p][15:8]};
        end
      end
    end
  end

  // Next state: bus slave, register writes, pin drivers
  always_comb begin
    st_next = st_reg;

    // Ack one cycle after the request, dropped the cycle after
    st_next.ack = req & ~st_reg.ack;
    if (req & ~st_reg.ack) begin
      st_next.dat = rd_data;
    end

    // Writes land at the edge where the master samples ack
    if (wr_go && in_range) begin
      if (idx == P4CS_IDX_CTRL_LO) begin
        st_next.ctrl[0] = wbyte;
      end else if (idx == P4CS_IDX_CTRL_HI) begin
        st_next.ctrl[1] = wbyte;
      end else if (idx == P4CS_IDX_POLARITY) begin
        st_next.pol = wbyte[P4CS_POL_LSB +: 4];
      end else if (idx == P4CS_IDX_PORT_DATA) begin
        st_next.latch = wbyte[3:0];
      end else begin
        for (int p = 0; p < PINS; p++) begin
          if (idx == P4CS_IDX_BASE_LO[p]) begin
            st_next.base[p][7:0] = wbyte;
          end else if (idx == P4CS_IDX_BASE_HI[p]) begin
            st_next.base[p][15:8] = wbyte;
          end
        end
      end
    end

    // Pin drivers per mode
    for (int p = 0; p < PINS; p++) begin
      if (p4cs_pin_mode(st_reg.ctrl, p) == P4CS_MODE_GPIO) begin
        // Quasi-bidirectional: drive low for 0, release to pull-up for 1
        st_next.pin_o[p]    = st_reg.latch[p];
        st_next.pin_oe_n[p] = st_reg.latch[p];
      end else begin
        // Strobe level follows the polarity bit
        st_next.pin_o[p]    = st_reg.pol[p] ? hit[p] : ~hit[p];
        st_next.pin_oe_n[p] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.ctrl     <= {P4CS_CTRL_RST, P4CS_CTRL_RST};
      st_reg.base     <= {P4CS_BASE_RST, P4CS_BASE_RST, P4CS_BASE_RST, P4CS_BASE_RST};
      st_reg.pol      <= P4CS_POL_RST;
      st_reg.latch    <= P4CS_LATCH_RST;
      st_reg.pin_o    <= P4CS_LATCH_RST;
      st_reg.pin_oe_n <= P4CS_LATCH_RST;
      st_reg.ack      <= 1'b0;
      st_reg.dat      <= 32'h00000000;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign wb_rsp.ack     = st_reg.ack;
  assign wb_rsp.dat     = st_reg.dat;
  assign port4_pin_o    = st_reg.pin_o;
  assign port4_pin_oe_n = st_reg.pin_oe_n;

endmodule

`default_nettype wire

// file: verification/p4cs_props.sv
// Purpose: Port-level checks of the port 4 decoder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every p4cs_top
`timescale 1ns/1ps
`default_nettype none
module p4cs_props
  import p4cs_pkg::*;
#(
  parameter int unsigned PINS = P4CS_PINS
) (
  input wire logic            clock,
  input wire logic            rst_n,
  input wire p4cs_wb_req_t    wb_req,
  input wire p4cs_wb_rsp_t    wb_rsp,
  input wire p4cs_ext_bus_t   ext_bus,
  input wire logic [PINS-1:0] port4_pin_i,
  input wire logic [PINS-1:0] port4_pin_o,
  input wire logic [PINS-1:0] port4_pin_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus request, bus strobe and a quiet cycle
  wire logic req = wb_req.cyc && wb_req.stb;
  wire logic bus = ext_bus.rd || ext_bus.wr;
  wire logic q   = !bus && !wb_rsp.ack;

  ack_pulse_a:
    assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held too long");
  ack_timing_a:
    assert property (req && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack missing");
  ack_cause_a:
    assert property (wb_rsp.ack |-> $past(req)) else $error("ack without request");
  read_upper_a:
    assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0) else $error("upper bits set");
  pins_quiet_a:
    assert property (q ##1 q |=> $stable(port4_pin_o) && $stable(port4_pin_oe_n))
      else $error("pin moved while idle");
  release_high_a:
    assert property ((port4_pin_oe_n & ~port4_pin_o) == '0) else $error("released pin low");
  reset_pins_a:
    assert property ($rose(rst_n) |-> port4_pin_oe_n == '1 && port4_pin_o == '1)
      else $error("pins not released");
  pin_cause_a:
    assert property ($changed({port4_pin_o, port4_pin_oe_n}) && !$past(wb_rsp.ack, 2)
      |-> $past(bus) || $past(bus, 2)) else $error("pin change without access");

  // Main scenarios reached
  cover property (ext_bus.rd ##1 $changed(port4_pin_o));
  cover property (ext_bus.wr ##1 $changed(port4_pin_o));
  cover property (req && wb_req.we ##1 wb_rsp.ack);
endmodule
bind p4cs_top p4cs_props #(.PINS(PINS)) props_u (.clock, .rst_n, .wb_req, .wb_rsp,
  .ext_bus, .port4_pin_i, .port4_pin_o, .port4_pin_oe_n);
`default_nettype wire

// file: verification/p4cs_ext_dev.sv
// Purpose: Pin side of the decoder: pull-ups on the port 4 pins
// Assumes: A pin is open while its oe_n is high
// Notes:   The resolved level feeds the pin inputs
`timescale 1ns/1ps
`default_nettype none
module p4cs_ext_dev #(
  parameter int unsigned PINS = 4
) (
  input  wire logic [PINS-1:0] pin_o,
  input  wire logic [PINS-1:0] pin_oe_n,
  output logic      [PINS-1:0] pin_lvl
);
  // Released pins go to the pull-up level
  assign pin_lvl = pin_o | pin_oe_n;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: Self-checking bench of the port 4 decoder
// Assumes: 10 MHz clock, registers over classic Wishbone
// Notes:   One pin is set up at a time; the others stay plain I/O
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import p4cs_pkg::*;
;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  p4cs_wb_req_t  req   = '0;
  p4cs_wb_rsp_t  rsp;
  p4cs_ext_bus_t eb    = '0;
  logic [3:0]    po, poe, lvl, ep, eo;
  logic [31:0]   rdv;
  logic [15:0]   a;
  logic [7:0]    v;
  logic          r, hit;
  int            error_cnt = 0;
  int            compares  = 0;
  logic [15:0]   base [4];
  logic [15:0]   mask [4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
  logic [15:0]   dif [5]  = '{16'h0, 16'h1, 16'h2, 16'h80, 16'h100};
  logic [3:0]    pl = 4'ha;

  // Clock and parts
  always #50 clock = ~clock;
  p4cs_top dut_u (.clock(clock), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp), .ext_bus(eb),
    .port4_pin_i(lvl), .port4_pin_o(po), .port4_pin_oe_n(poe));
  p4cs_ext_dev dev_u (.pin_o(po), .pin_oe_n(poe), .pin_lvl(lvl));

  task automatic finish_test;
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic Wishbone cycle, waiting for ack
  task automatic wb(input logic we, input logic [31:0] ad, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b1, we, ad, s, {24'h0, d}};
    do begin
      @(posedge clock);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rdv = rsp.dat;
    req <= '0;
    if (n == 20) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    wb(1'b1, {22'h0, i, 2'h0}, d, 4'h1);
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, {22'h0, i, 2'h0}, 8'h0, 4'hf);
    check("reg", rdv, {24'h0, e});
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rc(P4CS_IDX_CTRL_LO, 8'h0);
    rc(P4CS_IDX_CTRL_HI, 8'h0);
    rc(P4CS_IDX_POLARITY, 8'h0);
    wr(P4CS_IDX_POLARITY, 8'hff);
    rc(P4CS_IDX_POLARITY, 8'hf0);
    wr(P4CS_IDX_POLARITY, {pl, 4'h0});
    wb(1'b1, 32'h400 | {22'h0, P4CS_IDX_CTRL_LO, 2'h0}, 8'h5, 4'h1);
    wb(1'b1, {22'h0, P4CS_IDX_CTRL_HI, 2'h0}, 8'h5, 4'h0);
    rc(P4CS_IDX_CTRL_LO, 8'h0);
    rc(P4CS_IDX_CTRL_HI, 8'h0);
    rc(8'h10, 8'h0);
    for (int p = 0; p < 4; p++) begin
      base[p] = {8'h3c + 8'(p), 8'ha5 - 8'(p)};
      rc(P4CS_IDX_BASE_LO[p], 8'h0);
      wr(P4CS_IDX_BASE_LO[p], base[p][7:0]);
      wr(P4CS_IDX_BASE_HI[p], base[p][15:8]);
      rc(P4CS_IDX_BASE_LO[p], base[p][7:0]);
      rc(P4CS_IDX_BASE_HI[p], base[p][15:8]);
    end
    wr(P4CS_IDX_PORT_DATA, 8'h05);
    repeat (3) @(posedge clock);
    check("gpio", {24'h0, po, poe}, 32'h55);
    rc(P4CS_IDX_PORT_DATA, 8'h05);
    wr(P4CS_IDX_PORT_DATA, 8'h0f);
    // Every strobe mode (01, 10, 11) and compare width on every pin
    for (int p = 0; p < 4; p++)
      for (int m = 1; m < 4; m++)
        for (int c = 0; c < 4; c++) begin
          v = (p % 2) ? {2'(m), 2'(c), 4'h0} : {4'h0, 2'(m), 2'(c)};
          wr(P4CS_IDX_CTRL_LO, p < 2 ? v : 8'h0);
          wr(P4CS_IDX_CTRL_HI, p < 2 ? 8'h0 : v);
          for (int j = 0; j < 10; j++) begin
            a = base[p] ^ dif[j / 2];
            r = j[0];
            hit = ((a ^ base[p]) & mask[c]) == 16'h0 && (r ? m[0] : m[1]);
            ep = 4'hf;
            eo = 4'hf;
            ep[p] = pl[p] ~^ hit;
            eo[p] = 1'b0;
            @(posedge clock);
            eb <= '{a, r, !r};
            @(posedge clock);
            #1 check("pins", {24'h0, po, poe}, {24'h0, ep, eo});
            @(posedge clock);
            eb <= '{a, 1'b0, 1'b0};
            ep[p] = !pl[p];
            repeat (2) @(posedge clock);
            #1 check("idle", {28'h0, po}, {28'h0, ep});
          end
        end
    finish_test();
  end
endmodule
`default_nettype wire
